// ### hw/fes_host_ctrl.sv
// Host-side controller that sequences program, erase, reset and protect on a parallel NOR flash
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - Host detects completion by polling the status bit or toggle bit.
// - Earlier silicon: over 1024 suspend/resume cycles needs a 10 ms delay.
// - Host holds reset low at least 500 ns.
// - Host waits 70 ns after reset release before reading.
// - Host waits 70 ns after ready before chip or output enable low; the code applies this wait (rbOk) to reads only, and writes do not wait for it.
// - Temporary unprotect: high-voltage reset 4 us before any write.
// - Protect: output enable set up 4 us before write, 4 us per transition.
module fes_host_ctrl #(
	parameter int unsigned READY1_CYC     = fes_pkg::RDY1_CYC_DEF,
	parameter int unsigned SUSP_DELAY_CYC = fes_pkg::SDLY_CYC_DEF,
	parameter bit          EARLY_SILICON  = 1'b1
) (
	input  wire logic             sys_clk,
	input  wire logic             nrst,
	input  wire logic             cmdValid,
	input  wire fes_pkg::fesOp_t  cmdOp,
	input  wire logic [19:0]      cmdAddr,
	input  wire logic [15:0]      cmdData,
	input  wire logic             tempUnprotect,
	output logic                  cmdReady,
	output logic                  rspValid,
	output logic [15:0]           rspData,
	output fes_pkg::fesPins_t     flashPins,
	input  wire logic [15:0]      flashDqIn,
	input  wire logic             flashRyBy
);
	// ==========================================================
	// Types and state
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0, ST_RST_LO = 4'h1, ST_RST_WAIT = 4'h2, ST_WR_LO = 4'h3,
		ST_WR_HI = 4'h4, ST_POLL_WAIT = 4'h5, ST_RD_ACC = 4'h6, ST_HV_UP = 4'h7,
		ST_HV_PULSE = 4'h8, ST_HV_DOWN = 4'h9, ST_SR_DELAY = 4'hA, ST_DONE = 4'hB
	} fesState_t;

	fesState_t          st_q, st_d;
	fes_pkg::fesOp_t    op_q, op_d;
	fes_pkg::fesPins_t  pins_q, pins_d;
	logic [1:0]         rstPipe_q;
	logic               rstN;
	logic [15:0]        dqMeta_q, dqSync_q;
	logic               ryMeta_q, rySync_q;
	logic [23:0]        cnt_q, cnt_d;
	logic [7:0]         readyCnt_q;
	logic [11:0]        hvCnt_q;
	logic [10:0]        resumeCnt_q, resumeCnt_d;
	logic [19:0]        addr_q, addr_d;
	logic [15:0]        data_q, data_d, rdData_q, rdData_d;
	logic [2:0]         step_q, step_d;
	logic               poll_q, poll_d, wasBusy_q, wasBusy_d, delayDone_q, delayDone_d;
	logic               cmdReady_d, rspValid_d;

	// ==========================================================
	// Command sequence decode: address and word of each bus write
	function automatic logic [35:0] seqWord(input fes_pkg::fesOp_t op, input logic [2:0] step,
	                                        input logic [19:0] a, input logic [15:0] d);
		logic [35:0] w;
		w = {fes_pkg::UNLOCK_ADDR1, fes_pkg::UNLOCK_DATA1};
		case (step)
			3'h1: w = {fes_pkg::UNLOCK_ADDR2, fes_pkg::UNLOCK_DATA2};
			3'h2: w = {fes_pkg::UNLOCK_ADDR1,
			           (op == fes_pkg::FES_OP_PROGRAM) ? fes_pkg::CMD_PROGRAM : fes_pkg::CMD_ERASE};
			3'h3: w = (op == fes_pkg::FES_OP_PROGRAM) ? {a, d} : // One word per program
			          {fes_pkg::UNLOCK_ADDR1, fes_pkg::UNLOCK_DATA1};
			3'h4: w = {fes_pkg::UNLOCK_ADDR2, fes_pkg::UNLOCK_DATA2};
			3'h5: w = (op == fes_pkg::FES_OP_CHIP) ? {fes_pkg::UNLOCK_ADDR1, fes_pkg::CMD_CHIP} :
			          {a, fes_pkg::CMD_SECTOR}; // Sector taken from the upper address bits
			default: w = {fes_pkg::UNLOCK_ADDR1, fes_pkg::UNLOCK_DATA1};
		endcase
		if (op == fes_pkg::FES_OP_SUSPEND)
			w = {a, fes_pkg::CMD_SUSPEND};
		else if (op == fes_pkg::FES_OP_RESUME)
			w = {a, fes_pkg::CMD_RESUME};
		return w;
	endfunction : seqWord

	// ==========================================================
	// Decode of lengths, expected status and readiness
	wire logic [2:0]  seqLast  = (op_q == fes_pkg::FES_OP_PROGRAM) ? 3'h3 :
	                             (op_q == fes_pkg::FES_OP_CHIP || op_q == fes_pkg::FES_OP_SECTOR)
	                             ? 3'h5 : 3'h0;
	wire logic        isAlgo   = (op_q == fes_pkg::FES_OP_PROGRAM) ||
	                             (op_q == fes_pkg::FES_OP_CHIP) || (op_q == fes_pkg::FES_OP_SECTOR);
	// Erase finishes with 1, program with the true target bit
	wire logic        expQ7    = (op_q == fes_pkg::FES_OP_PROGRAM) ? data_q[fes_pkg::POLL_BIT] : 1'b1;
	wire logic        rbOk     = rySync_q && (readyCnt_q >= 8'(fes_pkg::RB_CYC));
	wire logic        hvOk     = !pins_q.resetHv || (hvCnt_q >= 12'(fes_pkg::RSP_CYC));
	wire logic        overLim  = EARLY_SILICON && (resumeCnt_q >= 11'(fes_pkg::SUSPEND_LIMIT));
	wire logic [23:0] rstWait  = wasBusy_q ? 24'(READY1_CYC + fes_pkg::RH_CYC - 1) :
	                             24'(fes_pkg::RDY2_CYC + fes_pkg::RH_CYC - 1);
	wire logic [35:0] curWord  = seqWord(op_q, step_q, addr_q, data_q);

	// ==========================================================
	// Reset release and pin synchronisers
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) rstPipe_q <= 2'b00;
		else       rstPipe_q <= {rstPipe_q[0], 1'b1};
	end
	assign rstN = rstPipe_q[1];

	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			{dqMeta_q, dqSync_q, ryMeta_q, rySync_q} <= '0;
		end else begin
			{dqMeta_q, ryMeta_q} <= {flashDqIn, flashRyBy};
			{dqSync_q, rySync_q} <= {dqMeta_q, ryMeta_q};
		end
	end

	// Ready age and high-voltage age, both saturating
	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			readyCnt_q <= 8'h00;
			hvCnt_q    <= 12'h000;
		end else begin
			readyCnt_q <= !rySync_q ? 8'h00 : readyCnt_q + {7'h00, readyCnt_q != 8'hFF};
			hvCnt_q    <= !(pins_q.resetHv || pins_q.oeHv) ? 12'h000 :
			              hvCnt_q + {11'h000, hvCnt_q != 12'hFFF};
		end
	end

	// ==========================================================
	// Sequencer next state; device verifies and erases alone, host only polls
	always_comb begin
		st_d = st_q; op_d = op_q; addr_d = addr_q; data_d = data_q; step_d = step_q;
		poll_d = poll_q; wasBusy_d = wasBusy_q; rdData_d = rdData_q;
		resumeCnt_d = resumeCnt_q; delayDone_d = delayDone_q;
		cmdReady_d = 1'b0; rspValid_d = 1'b0;
		case (st_q)
			ST_IDLE: begin
				cmdReady_d = hvOk; // Writes held off until unprotect voltage settles
				if (cmdValid && cmdReady) begin
					cmdReady_d = 1'b0; op_d = cmdOp; addr_d = cmdAddr; data_d = cmdData;
					step_d = 3'h0; poll_d = 1'b0; delayDone_d = 1'b0; wasBusy_d = !rySync_q;
					case (cmdOp)
						fes_pkg::FES_OP_READ:    st_d = ST_POLL_WAIT;
						fes_pkg::FES_OP_RESET:   st_d = ST_RST_LO;
						fes_pkg::FES_OP_PROTECT: st_d = ST_HV_UP;
						fes_pkg::FES_OP_RESUME:  st_d = overLim ? ST_SR_DELAY : ST_WR_LO;
						default:                 st_d = ST_WR_LO;
					endcase
				end
			end
			ST_WR_LO: if (cnt_q == 24'(fes_pkg::WP_CYC - 1)) st_d = ST_WR_HI;
			ST_WR_HI: if (cnt_q == 24'(fes_pkg::WPH_CYC - 1)) begin
				if (step_q != seqLast) begin
					step_d = step_q + 3'h1; st_d = ST_WR_LO;
				end else if (isAlgo) begin
					poll_d = 1'b1; st_d = ST_POLL_WAIT; // Completion found by polling
				end else begin
					if (op_q == fes_pkg::FES_OP_RESUME && resumeCnt_q != 11'h7FF)
						resumeCnt_d = resumeCnt_q + 11'h001;
					st_d = ST_DONE;
				end
			end
			// No read until the busy flag has had time to show and ready has aged
			ST_POLL_WAIT: if (cnt_q >= 24'(fes_pkg::BUSY_CYC) && rbOk) st_d = ST_RD_ACC;
			ST_RD_ACC: if (cnt_q == 24'(fes_pkg::ACC_CYC + fes_pkg::SYNC_STAGES)) begin
				rdData_d = dqSync_q;
				st_d = (!poll_q || dqSync_q[fes_pkg::POLL_BIT] == expQ7) ? ST_DONE : ST_POLL_WAIT;
			end
			ST_RST_LO: if (cnt_q == 24'(fes_pkg::RP_CYC - 1)) st_d = ST_RST_WAIT;
			// Device recovery bound by what it was doing, then release-to-read gap
			ST_RST_WAIT: if (cnt_q == rstWait) begin
				resumeCnt_d = 11'h000; st_d = ST_DONE;
			end
			ST_HV_UP: if (cnt_q == 24'(fes_pkg::VLHT_CYC + fes_pkg::OESP_CYC - 1)) st_d = ST_HV_PULSE;
			ST_HV_PULSE: if (cnt_q == 24'(fes_pkg::WPP_CYC - 1)) st_d = ST_HV_DOWN;
			ST_HV_DOWN: if (cnt_q == 24'(fes_pkg::VLHT_CYC - 1)) st_d = ST_DONE;
			ST_SR_DELAY: if (cnt_q == 24'(SUSP_DELAY_CYC - 1)) begin
				resumeCnt_d = 11'h000; delayDone_d = 1'b1; st_d = ST_WR_LO;
			end
			ST_DONE: begin
				rspValid_d = 1'b1; cmdReady_d = hvOk; st_d = ST_IDLE;
			end
			default: st_d = ST_IDLE;
		endcase
	end
	assign cnt_d = (st_d != st_q) ? 24'h000000 : cnt_q + 24'h000001;

	// Pin values follow the coming state so each phase starts on its first cycle
	always_comb begin
		pins_d = fes_pkg::PINS_IDLE;
		pins_d.resetHv = tempUnprotect;
		pins_d.addr = addr_d;
		case (st_d)
			ST_WR_LO: begin
				{pins_d.addr, pins_d.dq} = seqWord(op_d, step_d, addr_d, data_d);
				pins_d.ceN = 1'b0; pins_d.weN = 1'b0; pins_d.dqOe = 1'b1;
			end
			ST_WR_HI:  {pins_d.addr, pins_d.dq} = curWord;
			ST_RD_ACC: begin
				pins_d.ceN = 1'b0; pins_d.oeN = 1'b0;
			end
			ST_RST_LO: pins_d.resetN = 1'b0;
			ST_HV_UP: begin
				pins_d.a9Hv = 1'b1; pins_d.oeHv = 1'b1;
			end
			ST_HV_PULSE: begin
				pins_d.a9Hv = 1'b1; pins_d.oeHv = 1'b1; pins_d.ceN = 1'b0; pins_d.weN = 1'b0;
			end
			default: pins_d.resetHv = tempUnprotect;
		endcase
	end

	// ==========================================================
	// State registers
	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			st_q <= ST_IDLE; op_q <= fes_pkg::FES_OP_READ; pins_q <= fes_pkg::PINS_IDLE;
			cnt_q <= 24'h000000; addr_q <= 20'h00000; data_q <= 16'h0000; rdData_q <= 16'h0000;
			step_q <= 3'h0; poll_q <= 1'b0; wasBusy_q <= 1'b0; delayDone_q <= 1'b0;
			resumeCnt_q <= 11'h000; cmdReady <= 1'b0; rspValid <= 1'b0; rspData <= 16'h0000;
		end else begin
			st_q <= st_d; op_q <= op_d; pins_q <= pins_d; cnt_q <= cnt_d;
			addr_q <= addr_d; data_q <= data_d; rdData_q <= rdData_d; step_q <= step_d;
			poll_q <= poll_d; wasBusy_q <= wasBusy_d; delayDone_q <= delayDone_d;
			resumeCnt_q <= resumeCnt_d; cmdReady <= cmdReady_d; rspValid <= rspValid_d;
			rspData <= rdData_d;
		end
	end
	assign flashPins = pins_q;

	// ==========================================================
	// Checks on the pins this controller drives
	logic [7:0] lowCnt_q;
	logic [7:0] sinceRel_q;
	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			lowCnt_q <= 8'h00; sinceRel_q <= 8'hFF;
		end else begin
			lowCnt_q   <= pins_q.resetN ? 8'h00 : lowCnt_q + {7'h00, lowCnt_q != 8'hFF};
			sinceRel_q <= !pins_q.resetN ? 8'h00 : sinceRel_q + {7'h00, sinceRel_q != 8'hFF};
		end
	end

	AST_RESET_PULSE: assert property (@(posedge sys_clk) disable iff (!rstN)
		$rose(pins_q.resetN) |-> lowCnt_q >= 8'(fes_pkg::RP_CYC)) else $error("reset pulse short");
	AST_RESET_TO_READ: assert property (@(posedge sys_clk) disable iff (!rstN)
		$fell(pins_q.oeN) |-> sinceRel_q >= 8'(fes_pkg::RH_CYC)) else $error("read too soon after reset");
	AST_READY_TO_READ: assert property (@(posedge sys_clk) disable iff (!rstN)
		$fell(pins_q.oeN) |-> $past(rbOk)) else $error("read before ready recovery");
	AST_POLL_DONE: assert property (@(posedge sys_clk) disable iff (!rstN)
		(st_q == ST_RD_ACC && st_d == ST_DONE && poll_q) |-> dqSync_q[fes_pkg::POLL_BIT] == expQ7)
		else $error("done without status match");
	AST_SUSPEND_DELAY: assert property (@(posedge sys_clk) disable iff (!rstN)
		(st_q == ST_IDLE && st_d == ST_WR_LO && op_d == fes_pkg::FES_OP_RESUME) |-> !overLim)
		else $error("resume past limit without delay");
	AST_UNPROTECT_SETUP: assert property (@(posedge sys_clk) disable iff (!rstN)
		($fell(pins_q.weN) && pins_q.resetHv) |-> $past(hvCnt_q) >= 12'(fes_pkg::RSP_CYC - 1))
		else $error("write before unprotect setup");
	AST_PROTECT_OE_SETUP: assert property (@(posedge sys_clk) disable iff (!rstN)
		($fell(pins_q.weN) && pins_q.oeHv) |-> $past(hvCnt_q) >= 12'(fes_pkg::OESP_CYC))
		else $error("protect write before setup");
	AST_NO_EARLY_READ: assert property (@(posedge sys_clk) disable iff (!rstN)
		(st_q == ST_WR_HI && st_d == ST_POLL_WAIT) |-> ##1 (pins_q.oeN [*8]))
		else $error("array read right after algorithm start");

	COV_PROGRAM: cover property (@(posedge sys_clk) disable iff (!rstN)
		st_q == ST_DONE && op_q == fes_pkg::FES_OP_PROGRAM);
	COV_SECTOR: cover property (@(posedge sys_clk) disable iff (!rstN)
		st_q == ST_DONE && op_q == fes_pkg::FES_OP_SECTOR);
	COV_RESET_BUSY: cover property (@(posedge sys_clk) disable iff (!rstN)
		st_q == ST_RST_WAIT && wasBusy_q);
	COV_SUSP_DELAY: cover property (@(posedge sys_clk) disable iff (!rstN) delayDone_q);
endmodule : fes_host_ctrl

`default_nettype wire

// ### hw/fes_pkg.sv
// Package: pin bundle, opcodes, command words and timing counts for the flash host controller
package fes_pkg;
	// ==========================================================
	// Clock and timing (times as printed, counts derived)
	localparam int CLK_PERIOD_NS         = 4;
	localparam int WRITE_PULSE_NS        = 35;
	localparam int WRITE_HIGH_NS         = 30;
	localparam int READ_ACCESS_NS        = 70;
	localparam int BUSY_DELAY_NS         = 90;
	localparam int RESET_PULSE_MIN_NS    = 500;   // reset_pulse_min
	localparam int RESET_HIGH_BEFORE_NS  = 70;    // reset_high_before_read
	localparam int READY_TO_ENABLE_NS    = 70;    // ready_to_enable_recovery
	localparam int RECOVERY_IDLE_NS      = 500;   // reset_recovery_idle_time
	localparam int RECOVERY_BUSY_US      = 20;    // reset_recovery_busy_time
	localparam int UNPROTECT_SETUP_US    = 4;     // unprotect_reset_setup
	localparam int PROTECT_OE_SETUP_US   = 4;     // protect_oe_setup
	localparam int VOLTAGE_TRANS_US      = 4;     // protect_voltage_transition
	localparam int PROTECT_PULSE_NS      = 100;
	localparam int SUSPEND_DELAY_MS      = 10;
	localparam int SUSPEND_LIMIT         = 1024;
	localparam int SYNC_STAGES           = 2;
	// Least times round up
	localparam int WP_CYC   = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WPH_CYC  = (WRITE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACC_CYC  = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BUSY_CYC = (BUSY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RP_CYC   = (RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RH_CYC   = (RESET_HIGH_BEFORE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RB_CYC   = (READY_TO_ENABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RDY2_CYC = (RECOVERY_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RSP_CYC  = (UNPROTECT_SETUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OESP_CYC = (PROTECT_OE_SETUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int VLHT_CYC = (VOLTAGE_TRANS_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WPP_CYC  = (PROTECT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Defaults for the long waits, which the top module exposes as parameters
	localparam int RDY1_CYC_DEF = (RECOVERY_BUSY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SDLY_CYC_DEF = (SUSPEND_DELAY_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ==========================================================
	// Unlock and command words, word-mode addresses
	localparam logic [19:0] UNLOCK_ADDR1 = 20'h00555;
	localparam logic [19:0] UNLOCK_ADDR2 = 20'h002AA;
	localparam logic [15:0] UNLOCK_DATA1 = 16'h00AA;
	localparam logic [15:0] UNLOCK_DATA2 = 16'h0055;
	localparam logic [15:0] CMD_PROGRAM  = 16'h00A0;
	localparam logic [15:0] CMD_ERASE    = 16'h0080;
	localparam logic [15:0] CMD_CHIP     = 16'h0010;
	localparam logic [15:0] CMD_SECTOR   = 16'h0030;
	localparam logic [15:0] CMD_SUSPEND  = 16'h00B0;
	localparam logic [15:0] CMD_RESUME   = 16'h0030;
	localparam int SECTOR_LO_BIT = 12;   // sector_select_low_addr
	localparam int SECTOR_HI_BIT = 19;   // sector_select_high_addr
	localparam int POLL_BIT      = 7;    // polling_status_bit
	localparam int TOGGLE_BIT    = 6;    // toggle_status_bit

	// ==========================================================
	// Types
	typedef enum logic [2:0] {
		FES_OP_READ    = 3'h0,
		FES_OP_PROGRAM = 3'h1,
		FES_OP_CHIP    = 3'h2,
		FES_OP_SECTOR  = 3'h3,
		FES_OP_SUSPEND = 3'h4,
		FES_OP_RESUME  = 3'h5,
		FES_OP_RESET   = 3'h6,
		FES_OP_PROTECT = 3'h7
	} fesOp_t;

	typedef struct packed {
		logic        ceN;
		logic        oeN;
		logic        weN;
		logic        resetN;
		logic        resetHv;   // reset pin raised to high voltage
		logic        a9Hv;      // high_voltage_protect_addr raised
		logic        oeHv;      // output enable raised to high voltage
		logic        dqOe;      // data pins driven by the host
		logic [19:0] addr;
		logic [15:0] dq;
	} fesPins_t;

	localparam fesPins_t PINS_IDLE = '{ceN: 1'b1, oeN: 1'b1, weN: 1'b1, resetN: 1'b1,
		resetHv: 1'b0, a9Hv: 1'b0, oeHv: 1'b0, dqOe: 1'b0, addr: 20'h00000, dq: 16'h0000};
endpackage : fes_pkg

// ### test/fes_flash_model.sv
// Behavioural NOR flash device that answers the host controller's pins
`timescale 1ns/10ps
`default_nettype none
module fes_flash_model (
	input  wire logic              sys_clk,
	input  wire fes_pkg::fesPins_t pins,
	input  wire logic              slow,
	output logic [15:0]            dqOut,
	output logic                   ryBy,
	output int                     viol
);
	// ==========================================================
	// Array, algorithm state and edge times of the host pins
	logic [15:0] mem [logic [19:0]];
	logic [19:0] tAddr;
	logic [15:0] tData;
	int          op = 0, step = 0, left = 0, recov = 0;
	logic        tog = 1'b0;
	realtime     tRl = -1.0e9, reset_high_before_read = -1.0e9, tRdy = -1.0e9;
	realtime     tHv = -1.0e9, tOe = -1.0e9, tOeOff = -1.0e9;
	wire         wEnd = pins.ceN | pins.weN;
	wire         busy = (left != 0);
	function automatic logic [15:0] rd(input logic [19:0] a);
		return mem.exists(a) ? mem[a] : 16'hFFFF;
	endfunction : rd
	initial begin
		viol = 0;
		dqOut = 16'h0000;
	end
	// Ready follows the algorithm and the reset recovery
	assign ryBy = !busy && recov == 0;

	// ==========================================================
	// Command words land at the end of a write pulse; protect pulses carry none
	always @(posedge wEnd) begin
		if (pins.resetN && !pins.a9Hv && !busy) begin
			case (step)
				0, 3: step = (pins.addr == fes_pkg::UNLOCK_ADDR1
					&& pins.dq == fes_pkg::UNLOCK_DATA1) ? step + 1 : 0;
				1, 4: step = (pins.addr == fes_pkg::UNLOCK_ADDR2
					&& pins.dq == fes_pkg::UNLOCK_DATA2) ? step + 1 : 0;
				2: step = (pins.dq == fes_pkg::CMD_PROGRAM) ? 6
					: (pins.dq == fes_pkg::CMD_ERASE) ? 3 : 0;
				default: begin
					tAddr = pins.addr;
					tData = pins.dq;
					op = (step == 6) ? 1 : (pins.dq == fes_pkg::CMD_CHIP) ? 2 : 3;
					left = (step == 6) ? (slow ? 400 : 12) : 30;
					step = 0;
				end
			endcase
		end
	end

	// Algorithm timer; the result lands as the count runs out
	// Runs on the falling edge so ready and data never race the host's sampling edge
	always @(negedge sys_clk) begin
		if (recov != 0) recov = recov - 1;
		if (left == 1 && op == 1) mem[tAddr] = rd(tAddr) & tData;
		if (left == 1 && op == 2) mem.delete();
		if (left == 1 && op == 3)
			foreach (mem[k]) if (k[19:12] == tAddr[19:12]) mem[k] = 16'hFFFF;
		if (left != 0) left = left - 1;
		// A released bus changes every cycle so a stale word never passes
		if (pins.ceN || pins.oeN) dqOut = ~dqOut;
		else if (busy) dqOut = {8'h00, (op == 1) ? ~tData[7] : 1'b0, tog, 6'h00};
		else dqOut = rd(pins.addr);
	end
	always @(negedge pins.oeN) if (busy) tog = ~tog;

	// ==========================================================
	// Hardware reset aborts; recovery sits far inside both limits
	always @(negedge pins.resetN) begin
		tRl = $realtime;
		recov = busy ? 40 : 0;
		left = 0;
		step = 0;
	end
	always @(posedge pins.resetN) begin
		reset_high_before_read = $realtime;
		if (reset_high_before_read - tRl < 500.0) viol++;
	end

	// Host setup and recovery times; a time zero ready edge is power-up, not an event
	always @(posedge ryBy) if ($realtime > 0) tRdy = $realtime;
	always @(posedge pins.resetHv) tHv = $realtime;
	always @(posedge pins.oeHv) tOe = $realtime;
	always @(negedge pins.oeHv) tOeOff = $realtime;
	always @(negedge pins.oeN) if ($realtime - reset_high_before_read < 70.0 || $realtime - tRdy < 70.0) viol++;
	always @(negedge pins.ceN) if ($realtime - tRdy < 70.0 || $realtime - tOeOff < 4000.0) viol++;
	always @(negedge wEnd) if (pins.resetHv && $realtime - tHv < 4000.0) viol++;
	always @(negedge pins.weN) if (pins.a9Hv && $realtime - tOe < 4000.0) viol++;
endmodule : fes_flash_model
`default_nettype wire

// ### test/fes_host_ctrl_bench.sv
// Random and corner-case bench for the flash host controller against a flash model
`timescale 1ns/10ps
`default_nettype none
module fes_host_ctrl_bench;
	// ==========================================================
	// Shortened long waits keep the run small
	localparam int RDY1 = 50;
	localparam int SDLY = 40;
	localparam logic [19:0] SEC [3] = '{20'hA5123, 20'hA4123, 20'h25123};
	logic              sys_clk;
	logic              nrst;
	logic              cmdValid;
	fes_pkg::fesOp_t   cmdOp;
	logic [19:0]       cmdAddr;
	logic [15:0]       cmdData;
	logic              tempUnprotect;
	logic              cmdReady;
	logic              rspValid;
	logic [15:0]       rspData;
	fes_pkg::fesPins_t flashPins;
	logic [15:0]       flashDqIn;
	logic              flashRyBy;
	logic              slow;
	int                viol;
	int                lat;
	int                n_errors = 0;
	int                total_checks = 0;
	logic [15:0]       shadow [logic [19:0]];

	fes_host_ctrl #(.READY1_CYC(RDY1), .SUSP_DELAY_CYC(SDLY), .EARLY_SILICON(1'b1)) dut (
		.sys_clk(sys_clk), .nrst(nrst), .cmdValid(cmdValid), .cmdOp(cmdOp),
		.cmdAddr(cmdAddr), .cmdData(cmdData), .tempUnprotect(tempUnprotect),
		.cmdReady(cmdReady), .rspValid(rspValid), .rspData(rspData),
		.flashPins(flashPins), .flashDqIn(flashDqIn), .flashRyBy(flashRyBy));
	fes_flash_model flash (.sys_clk(sys_clk), .pins(flashPins), .slow(slow),
		.dqOut(flashDqIn), .ryBy(flashRyBy), .viol(viol));

	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	// ==========================================================
	// Compares, expectation and command tasks (entered at a falling edge)
	task automatic check_data(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check_data
	task automatic check_cnt(input int got, input int exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check_cnt
	function automatic logic [15:0] exp_rd(input logic [19:0] a);
		return shadow.exists(a) ? shadow[a] : 16'hFFFF;
	endfunction : exp_rd
	// Request raised once ready shows and held one cycle, then a bounded wait for the finish pulse
	task automatic run(input fes_pkg::fesOp_t op, input logic [19:0] a, input logic [15:0] d);
		for (int n = 0; cmdReady !== 1'b1 && n < 5000; n++) @(negedge sys_clk);
		cmdOp = op;
		cmdAddr = a;
		cmdData = d;
		cmdValid = 1'b1;
		@(negedge sys_clk);
		cmdValid = 1'b0;
		for (lat = 1; rspValid !== 1'b1 && lat < 20000; lat++) @(negedge sys_clk);
		check_cnt(int'(lat < 20000), 1);
		check_data(16'(flashRyBy), 16'h0001);
	endtask : run
	task automatic rd(input logic [19:0] a);
		run(fes_pkg::FES_OP_READ, a, 16'h0000);
		check_data(rspData, exp_rd(a));
	endtask : rd
	task automatic prog(input logic [19:0] a, input logic [15:0] d);
		slow = 1'($urandom);
		run(fes_pkg::FES_OP_PROGRAM, a, d);
		shadow[a] = exp_rd(a) & d;
	endtask : prog
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : tally_and_finish

	// ==========================================================
	// Main sequence
	initial begin
		logic [19:0] a;
		logic [15:0] d;
		nrst = 1'b0;
		cmdValid = 1'b0;
		cmdOp = fes_pkg::FES_OP_READ;
		cmdAddr = 20'h00000;
		cmdData = 16'h0000;
		tempUnprotect = 1'b0;
		slow = 1'b0;
		void'($urandom(31));
		repeat (3) @(negedge sys_clk);
		nrst = 1'b1;
		check_cnt(int'(flashPins === fes_pkg::PINS_IDLE), 1);
		repeat (4) @(negedge sys_clk);
		check_data(16'(cmdReady), 16'h0001);
		$display("test reset done");
		// Random words; odd passes program again with fewer ones
		for (int i = 0; i < 8; i++) begin
			a = 20'($urandom);
			d = 16'($urandom);
			prog(a, d);
			if (i % 2 == 1) prog(a, d & 16'($urandom));
			rd(a);
			rd(a ^ 20'h00001);
		end
		$display("test program done");
		// Neighbours differ only in the lowest and highest sector bits
		foreach (SEC[i]) prog(SEC[i], 16'h0F00 | 16'(i));
		run(fes_pkg::FES_OP_SECTOR, 20'hA5FFF, 16'h0000);
		foreach (shadow[k]) if (k[19:12] == 8'hA5) shadow[k] = 16'hFFFF;
		foreach (SEC[i]) rd(SEC[i]);
		run(fes_pkg::FES_OP_CHIP, 20'h00000, 16'h0000);
		shadow.delete();
		foreach (SEC[i]) rd(SEC[i]);
		$display("test erase done");
		// Only the resume after 1024 counted ones carries the long delay
		run(fes_pkg::FES_OP_SUSPEND, 20'h00000, 16'h0000);
		for (int i = 1; i <= 1026; i++) begin
			run(fes_pkg::FES_OP_RESUME, 20'h00000, 16'h0000);
			check_cnt(int'(lat >= SDLY), int'(i == 1025));
		end
		$display("test suspend done");
		run(fes_pkg::FES_OP_RESET, 20'h00000, 16'h0000);
		// Pulse, idle recovery and release-to-read gap all pass before the finish
		check_cnt(int'(lat >= fes_pkg::RP_CYC + fes_pkg::RDY2_CYC + fes_pkg::RH_CYC), 1);
		rd(20'($urandom));
		run(fes_pkg::FES_OP_PROTECT, 20'hA5000, 16'h0000);
		// Rise with setup, the pulse, then the falling transition
		check_cnt(int'(lat >= fes_pkg::OESP_CYC + 2 * fes_pkg::VLHT_CYC + fes_pkg::WPP_CYC), 1);
		rd(20'hA5000);
		$display("test reset and protect done");
		tempUnprotect = 1'b1;
		repeat (4) @(negedge sys_clk);
		check_data(16'(cmdReady), 16'h0000);
		prog(20'h12345, 16'h00F0);
		tempUnprotect = 1'b0;
		rd(20'h12345);
		check_cnt(viol, 0);
		$display("test unprotect done");
		tally_and_finish();
	end

	// Cut a hang well beyond the expected run of some 30000 cycles
	initial begin
		#(80000 * 4);
		n_errors++;
		tally_and_finish();
	end
endmodule : fes_host_ctrl_bench
`default_nettype wire
